// file: inc/gpio_exp_pkg.sv
/*
 Constants and types for the 24-pin two-wire I/O expander.
 Assumes a single 24-bit port split into three 8-bit banks.
*/
`default_nettype none
package gpio_exp_pkg;
    // Upper six bits of the 7-bit target address; the strap adds bit 0
    localparam logic [5:0]  ADDR_HI      = 6'h11;
    // Reset values of the writable register groups
    localparam logic [7:0]  CMD_RST      = 8'h00;
    localparam logic [23:0] OUT_RST      = 24'hffffff;
    localparam logic [23:0] POL_RST      = 24'h000000;
    localparam logic [23:0] CFG_RST      = 24'hffffff;
    // Command byte field positions
    localparam int          AUTOSTEP_BIT = 7;
    localparam int          GRP_HI       = 3;
    localparam int          GRP_LO       = 2;
    // Register groups selected by command bits 3:2
    localparam logic [1:0]  GRP_IN       = 2'h0;
    localparam logic [1:0]  GRP_OUT      = 2'h1;
    localparam logic [1:0]  GRP_POL      = 2'h2;
    localparam logic [1:0]  GRP_CFG      = 2'h3;
    // Bank index 3 of every group is reserved
    localparam logic [1:0]  IDX_LAST     = 2'h2;
    localparam logic [1:0]  IDX_RSVD     = 2'h3;
    // Last bit of a byte
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    // Which byte of a transaction is being received
    localparam logic [1:0]  KIND_ADDR    = 2'h0;
    localparam logic [1:0]  KIND_CMD     = 2'h1;
    localparam logic [1:0]  KIND_DATA    = 2'h2;

    // Bus state machine states
    typedef enum logic [3:0] {
        S_IDLE,
        S_RECV,
        S_WFALL,
        S_ACK_OUT,
        S_SEND,
        S_ACK_IN,
        S_OTHER,
        S_IGNORE
    } state_t;
endpackage : gpio_exp_pkg
`default_nettype wire

// file: core/gpio_expander.sv
/*
 Two-wire target with 24 port pins, direction, polarity and latch banks,
 and a change interrupt. Assumes SDA, INT and the port pins are resolved
 outside from value plus active-low enable; SCL drives both SCL_IN and
 the link clock port.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_expander
    import gpio_exp_pkg::*;
(
    input  wire logic        CLK_SYS_IN,      // System clock
    input  wire logic        RST_B_IN,        // Reset pin, active low
    input  wire logic        SCL_LINK_CLK_IN, // Bus clock as a clock
    input  wire logic        SCL_IN,          // Bus clock as a level
    input  wire logic        SDA_IN,          // Data line level
    output wire logic        SDA_OUT,         // Data drive value
    output wire logic        SDA_OE_B_OUT,    // Data enable, low drives
    input  wire logic        ADDR_STRAP_IN,   // Address bit 0 strap
    input  wire logic        SUPPLY_OK_IN,    // Port supply above threshold
    input  wire logic [23:0] PORT_IN,         // Pin levels
    output wire logic [23:0] PORT_OUT,        // Pin drive values
    output wire logic [23:0] PORT_OE_B_OUT,   // Pin enables, low drives
    output wire logic        INT_OUT,         // Interrupt drive value
    output wire logic        INT_OE_B_OUT     // Interrupt enable, low drives
);

    // Whole system-clock state of the block; the link-domain toggle is kept apart
    typedef struct packed {
        state_t      state;    // Bus state
        logic [2:0]  bits;     // Bit counter
        logic [7:0]  sh;       // Shift register, both directions
        logic [1:0]  kind;     // Byte kind being received
        logic        rw;       // Direction of the current transfer
        logic        ours;     // This transaction addressed us
        logic        acked;    // Byte acknowledged
        logic        sda_oe_b; // SDA enable
        logic [7:0]  cmd;      // Command pointer
        logic [23:0] outl;     // Output latch
        logic [23:0] pol;      // Polarity inversion
        logic [23:0] cfg;      // Direction, 1 = input
        logic [23:0] iref;     // Stored input levels for change detect
        logic        int_oe_b; // Interrupt enable
        logic        blocked;  // Waiting for the extra SCL pulse
        logic        scl_s1, scl_s2, scl_s3;       // SCL synchroniser and history
        logic        sda_s1, sda_s2, sda_s3;       // SDA synchroniser and history
        logic        strap_s1, strap_s2;           // Strap synchroniser
        logic        sup_s1, sup_s2;               // Supply-good synchroniser
        logic [23:0] pin_s1, pin_s2;               // Pin synchroniser
        logic        tog_s1, tog_s2, tog_s3;       // Link toggle crossing and history
    } st_t;

    st_t  r_reg;      // Registered state
    st_t  r_next;     // Next state
    logic tog_reg;    // Link-domain SCL pulse toggle

    // Byte of a 24-bit bank, reserved index reads as zero
    function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [1:0] i);
        case (i)
            2'h0:    get_byte = v[7:0];
            2'h1:    get_byte = v[15:8];
            2'h2:    get_byte = v[23:16];
            default: get_byte = 8'h00;
        endcase
    endfunction : get_byte

    // Replace one byte of a bank, reserved index changes nothing
    function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] i,
                                             input logic [7:0] b);
        put_byte = v;
        case (i)
            2'h0:    put_byte[7:0]   = b;
            2'h1:    put_byte[15:8]  = b;
            2'h2:    put_byte[23:16] = b;
            default: put_byte = v;
        endcase
    endfunction : put_byte

    // Pointer step within a group of three, skipping the reserved slot
    function automatic logic [1:0] step_idx(input logic [1:0] i);
        step_idx = (i >= IDX_LAST) ? 2'h0 : i + 2'h1;
    endfunction : step_idx

    // Decoded events and views of the current state
    logic       scl_rise;  // SCL rising
    logic       scl_fall;  // SCL falling
    logic       start_ev;  // Start or repeated start
    logic       stop_ev;   // Stop
    logic       tog_ev;    // One SCL pulse seen by the link domain
    logic [1:0] grp;       // Group selected by pointer
    logic [1:0] idx;       // Bank selected by pointer
    logic [7:0] rd_val;    // Register byte under the pointer
    logic [7:0] sh_in;     // Shift register after taking SDA
    logic       pend;      // Unreported input change exists
    logic       wr_fire;   // Data byte written this cycle

    assign scl_rise = r_reg.scl_s2 & ~r_reg.scl_s3;
    assign scl_fall = ~r_reg.scl_s2 & r_reg.scl_s3;
    assign start_ev = r_reg.scl_s2 & r_reg.scl_s3 & r_reg.sda_s3 & ~r_reg.sda_s2;
    assign stop_ev  = r_reg.scl_s2 & r_reg.scl_s3 & ~r_reg.sda_s3 & r_reg.sda_s2;
    assign tog_ev   = r_reg.tog_s2 ^ r_reg.tog_s3;
    assign grp      = r_reg.cmd[GRP_HI:GRP_LO];
    assign idx      = r_reg.cmd[1:0];
    assign sh_in    = {r_reg.sh[6:0], r_reg.sda_s2};
    assign wr_fire  = (r_reg.state == S_ACK_OUT) && scl_rise && !r_reg.rw
                      && (r_reg.kind == KIND_DATA);
    // Only pins set as inputs can differ; a pin just turned to input
    // whose level differs from the stored value fires at once
    assign pend     = |((r_reg.pin_s2 ^ r_reg.iref) & r_reg.cfg);

    // Read mux over the four groups
    always_comb begin
        case (grp)
            GRP_IN:  rd_val = get_byte(r_reg.pin_s2 ^ r_reg.pol, idx);
            GRP_OUT: rd_val = get_byte(r_reg.outl, idx);
            GRP_POL: rd_val = get_byte(r_reg.pol, idx);
            default: rd_val = get_byte(r_reg.cfg, idx);
        endcase
    end

    // Link domain: flips on every SCL rise; async reset keeps it defined
    // even when SCL stands still during reset
    always_ff @(posedge SCL_LINK_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tog_reg <= 1'b0;
        end else begin
            tog_reg <= ~tog_reg;
        end
    end

    // Next-state logic for the whole system-clock domain
    always_comb begin
        r_next = r_reg;
        // Two-flop synchronisers, plus one history stage for SCL, SDA and the toggle
        r_next.scl_s1   = SCL_IN;
        r_next.scl_s2   = r_reg.scl_s1;
        r_next.scl_s3   = r_reg.scl_s2;
        r_next.sda_s1   = SDA_IN;
        r_next.sda_s2   = r_reg.sda_s1;
        r_next.sda_s3   = r_reg.sda_s2;
        r_next.strap_s1 = ADDR_STRAP_IN;
        r_next.strap_s2 = r_reg.strap_s1;
        r_next.sup_s1   = SUPPLY_OK_IN;
        r_next.sup_s2   = r_reg.sup_s1;
        r_next.pin_s1   = PORT_IN;
        r_next.pin_s2   = r_reg.pin_s1;
        r_next.tog_s1   = tog_reg;
        r_next.tog_s2   = r_reg.tog_s1;
        r_next.tog_s3   = r_reg.tog_s2;
        // Extra SCL pulse after a command re-enables reporting
        if (tog_ev) begin
            r_next.blocked = 1'b0;
        end
        case (r_reg.state)
            S_RECV: begin
                // Sample on the rising edge, MSB first
                if (scl_rise) begin
                    r_next.sh   = sh_in;
                    r_next.bits = r_reg.bits + 3'h1;
                    if (r_reg.bits == LAST_BIT) begin
                        if (r_reg.kind != KIND_ADDR) begin
                            r_next.state = S_WFALL;
                        end else if (sh_in[7:1] == {ADDR_HI, r_reg.strap_s2}) begin
                            r_next.rw    = sh_in[0];
                            r_next.state = S_WFALL;
                        end else if (sh_in[0] && r_reg.cmd == CMD_RST) begin
                            r_next.state = S_OTHER;
                        end else begin
                            r_next.state = S_IGNORE;
                        end
                    end
                end
            end
            S_WFALL: begin
                // Pull SDA low once SCL is low
                if (scl_fall) begin
                    r_next.sda_oe_b = 1'b0;
                    r_next.state    = S_ACK_OUT;
                end
            end
            S_ACK_OUT: begin
                // Act on the byte at the ack clock rise
                if (scl_rise) begin
                    if (r_reg.kind == KIND_ADDR) begin
                        r_next.ours = 1'b1;
                        r_next.kind = KIND_CMD;
                    end else if (r_reg.kind == KIND_CMD) begin
                        r_next.cmd  = r_reg.sh;
                        r_next.kind = KIND_DATA;
                    end else begin
                        // Input group ignores writes
                        if (grp == GRP_OUT) begin
                            r_next.outl = put_byte(r_reg.outl, idx, r_reg.sh);
                        end else if (grp == GRP_POL) begin
                            r_next.pol = put_byte(r_reg.pol, idx, r_reg.sh);
                        end else if (grp == GRP_CFG) begin
                            r_next.cfg = put_byte(r_reg.cfg, idx, r_reg.sh);
                        end
                        if (r_reg.cmd[AUTOSTEP_BIT]) begin
                            r_next.cmd[1:0] = step_idx(idx);
                        end
                    end
                end
                // On the fall, drive the first bit of a read byte, or release SDA to receive the next byte
                if (scl_fall) begin
                    r_next.bits = 3'h0;
                    if (r_reg.rw) begin
                        r_next.sh       = rd_val;
                        r_next.sda_oe_b = rd_val[7];
                        r_next.state    = S_SEND;
                    end else begin
                        r_next.sda_oe_b = 1'b1;
                        r_next.state    = S_RECV;
                    end
                end
            end
            S_SEND: begin
                // Next bit after each falling edge; released for the ack
                if (scl_fall) begin
                    if (r_reg.bits == LAST_BIT) begin
                        r_next.sda_oe_b = 1'b1;
                        r_next.state    = S_ACK_IN;
                    end else begin
                        r_next.sh       = {r_reg.sh[6:0], 1'b0};
                        r_next.sda_oe_b = r_reg.sh[6];
                        r_next.bits     = r_reg.bits + 3'h1;
                    end
                end
            end
            S_ACK_IN: begin
                // Ack or nack: reading an input bank clears its change
                if (scl_rise) begin
                    r_next.acked = ~r_reg.sda_s2;
                    if (grp == GRP_IN) begin
                        r_next.iref = put_byte(r_reg.iref, idx,
                                               get_byte(r_reg.pin_s2, idx));
                    end
                    if (!r_reg.sda_s2 && r_reg.cmd[AUTOSTEP_BIT]) begin
                        r_next.cmd[1:0] = step_idx(idx);
                    end
                end
                if (scl_fall) begin
                    r_next.bits = 3'h0;
                    if (r_reg.acked) begin
                        r_next.sh       = rd_val;
                        r_next.sda_oe_b = rd_val[7];
                        r_next.state    = S_SEND;
                    end else begin
                        r_next.state = S_IGNORE;
                    end
                end
            end
            S_OTHER: begin
                // Another target acks a read: the known flaw clears INT
                if (scl_rise) begin
                    if (!r_reg.sda_s2) begin
                        r_next.iref = r_reg.pin_s2;
                    end
                    r_next.state = S_IGNORE;
                end
            end
            default: begin // Idle or ignoring: wait for start
            end
        endcase

        // Start anywhere restarts address reception
        if (start_ev) begin
            r_next.state    = S_RECV;
            r_next.bits     = 3'h0;
            r_next.kind     = KIND_ADDR;
            r_next.sda_oe_b = 1'b1;
        end
        // Stop ends everything; our own stop clears and blocks INT
        if (stop_ev) begin
            r_next.state    = S_IDLE;
            r_next.sda_oe_b = 1'b1;
            r_next.ours     = 1'b0;
            if (r_reg.ours) begin
                r_next.iref    = r_reg.pin_s2;
                r_next.blocked = 1'b1;
            end
        end
        // Report only while not blocked
        r_next.int_oe_b = ~(pend & ~r_reg.blocked);

        // Pin reset and loss of supply-good both force defaults
        if (!RST_B_IN || !r_reg.sup_s2) begin
            r_next.state    = S_IDLE;
            r_next.bits     = 3'h0;
            r_next.sh       = 8'h00;
            r_next.kind     = KIND_ADDR;
            r_next.rw       = 1'b0;
            r_next.ours     = 1'b0;
            r_next.acked    = 1'b0;
            r_next.sda_oe_b = 1'b1;
            r_next.cmd      = CMD_RST;
            r_next.outl     = OUT_RST;
            r_next.pol      = POL_RST;
            r_next.cfg      = CFG_RST;
            r_next.iref     = r_reg.pin_s2;
            r_next.int_oe_b = 1'b1;
            r_next.blocked  = 1'b0;
        end
        // The pin reset also clears the supply and toggle history
        if (!RST_B_IN) begin
            r_next.sup_s1 = 1'b0;
            r_next.sup_s2 = 1'b0;
            r_next.tog_s1 = 1'b0;
            r_next.tog_s2 = 1'b0;
            r_next.tog_s3 = 1'b0;
        end
    end

    // State register
    always_ff @(posedge CLK_SYS_IN) begin
        r_reg <= r_next;
    end

    // Open-drain lines only ever pull low
    assign SDA_OUT       = 1'b0;
    assign SDA_OE_B_OUT  = r_reg.sda_oe_b;
    assign PORT_OUT      = r_reg.outl;
    assign PORT_OE_B_OUT = r_reg.cfg;
    assign INT_OUT       = 1'b0;
    assign INT_OE_B_OUT  = r_reg.int_oe_b;

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_B_IN);

    a_reset_dflt: assert property (disable iff (1'b0) !RST_B_IN |=>
        PORT_OE_B_OUT == CFG_RST && PORT_OUT == OUT_RST && INT_OE_B_OUT)
        else $error("defaults not restored by reset");
    a_supply_hold: assert property (!r_reg.sup_s2 |=>
        PORT_OE_B_OUT == CFG_RST && SDA_OE_B_OUT)
        else $error("port driven before supply good");
    a_out_write: assert property (wr_fire && grp == GRP_OUT |=>
        get_byte(PORT_OUT, $past(idx)) == get_byte(put_byte(24'h0, $past(idx),
        $past(r_reg.sh)), $past(idx)))
        else $error("latch write not on pins");
    a_cfg_write: assert property (wr_fire && grp == GRP_CFG |=>
        get_byte(PORT_OE_B_OUT, $past(idx)) == get_byte(put_byte(24'h0,
        $past(idx), $past(r_reg.sh)), $past(idx)))
        else $error("direction write not applied");
    a_out_quiet: assert property (pend == 1'b0 |=> INT_OE_B_OUT)
        else $error("interrupt without input change");
    a_int_block: assert property (r_reg.blocked |=> INT_OE_B_OUT)
        else $error("interrupt while awaiting SCL pulse");
    a_ack_low: assert property (r_reg.state == S_ACK_OUT |-> !SDA_OE_B_OUT)
        else $error("ack not held low");
    a_addr_match: assert property (r_reg.state == S_RECV && scl_rise
        && r_reg.kind == KIND_ADDR && r_reg.bits == LAST_BIT
        && sh_in[7:1] == {ADDR_HI, r_reg.strap_s2} |=> ##[1:1000] !SDA_OE_B_OUT)
        else $error("own address not acked");
    a_stop_idle: assert property (stop_ev |=> r_reg.state == S_IDLE
        && SDA_OE_B_OUT)
        else $error("stop did not abandon transfer");
    a_nack_free: assert property (r_reg.state == S_ACK_IN && scl_rise
        && r_reg.sda_s2 |=> SDA_OE_B_OUT[*2])
        else $error("SDA held after nack");
    a_read_clear: assert property (r_reg.state == S_ACK_IN && scl_rise
        && grp == GRP_IN && idx != IDX_RSVD |=>
        get_byte(r_reg.iref, $past(idx)) == get_byte($past(r_reg.pin_s2), $past(idx)))
        else $error("read did not clear change");

    c_read_byte: cover property (r_reg.state == S_ACK_IN && scl_rise);
    c_latch_wr: cover property (wr_fire && grp == GRP_OUT);
    c_int_fire: cover property ($fell(INT_OE_B_OUT));
    c_foreign: cover property (r_reg.state == S_OTHER && scl_rise && !r_reg.sda_s2);

endmodule : gpio_expander
`default_nettype wire

// file: sim/i2c_master_model.sv
/*
 Two-wire bus master model: start, stop, byte write and byte read.
 Assumes the bench resolves SDA with a pull-up from all drivers.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input  wire logic sda_in,  // Resolved data line
    output var  logic scl_out, // Bus clock, high while idle
    output var  logic sda_out  // Data drive, 1 means released
);
    // Idle bus: both lines left to the pull-up
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // One 32 ns bit slot; the target answers within three system clocks
    // of SCL falling, well ahead of the sample point
    task automatic slot(input logic b, output logic s);
        #8 sda_out = b;
        #8 scl_out = 1'b1;
        #8 s = sda_in;
        #8 scl_out = 1'b0;
    endtask : slot
    // Start or repeated start
    task automatic start();
        sda_out = 1'b1;
        #24 scl_out = 1'b1;
        #24 sda_out = 1'b0;
        #24 scl_out = 1'b0;
    endtask : start
    // Stop, then the bus rests high
    task automatic stop();
        #24 sda_out = 1'b0;
        #24 scl_out = 1'b1;
        #24 sda_out = 1'b1;
    endtask : stop
    // Extra clock pulse so input edges are reported again
    task automatic pulse();
        #16 scl_out = 1'b0;
        #16 scl_out = 1'b1;
        #24;
    endtask : pulse
    // Byte to the target, MSB first, then its ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], s);
        end
        slot(1'b1, s);
        ack = ~s;
    endtask : wbyte
    // Byte from the target; nack ends the read
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, d[i]);
        end
        slot(~mack, s);
    endtask : rbyte
endmodule : i2c_master_model
`default_nettype wire

// file: sim/tb.sv
/*
 Self-checking bench for the two-wire I/O expander.
 Assumes a pull-up on SDA and INT; input pins take their levels from ext_pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_sys, rst_b, strap, sup_ok;
    logic [23:0] ext_pins; // Levels put on pins from outside
    logic [7:0]  r0, r1;   // Read-back bytes
    logic        ack;      // Ack seen by the master
    int          err_count, comparisons;
    wire logic        scl, sda_m, sda_oe_b, sda_d, int_d, int_oe_b;
    wire logic [23:0] port_d, port_oe_b;
    // Open-drain lines resolve to the pull-up unless pulled low
    wire logic        sda = sda_m & (sda_oe_b | sda_d);
    wire logic        int_line = int_oe_b | int_d;
    wire logic [23:0] pins = (port_oe_b & ext_pins) | (~port_oe_b & port_d);

    gpio_expander u_dut (.CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b),
        .SCL_LINK_CLK_IN(scl), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_d),
        .SDA_OE_B_OUT(sda_oe_b), .ADDR_STRAP_IN(strap), .SUPPLY_OK_IN(sup_ok),
        .PORT_IN(pins), .PORT_OUT(port_d), .PORT_OE_B_OUT(port_oe_b),
        .INT_OUT(int_d), .INT_OE_B_OUT(int_oe_b));
    i2c_master_model u_mst (.sda_in(sda), .scl_out(scl), .sda_out(sda_m));

    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Watchdog against a hung bus
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Bounded wait for the interrupt line to reach a level
    task automatic wait_int(input logic lvl);
        int n;
        n = 0;
        while (int_line !== lvl && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (int_line !== lvl) begin
            err_count++;
            give_verdict();
        end
    endtask : wait_int
    // Write command and two data bytes
    task automatic wr(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] b);
        u_mst.start();
        u_mst.wbyte(8'h44, ack);
        chk(24'(ack), 24'h1);
        u_mst.wbyte(cmd, ack);
        chk(24'(ack), 24'h1);
        u_mst.wbyte(a, ack);
        u_mst.wbyte(b, ack);
        u_mst.stop();
        u_mst.pulse();
    endtask : wr
    // Set pointer, repeated start, read two bytes
    task automatic rd(input logic [7:0] cmd);
        u_mst.start();
        u_mst.wbyte(8'h44, ack);
        u_mst.wbyte(cmd, ack);
        u_mst.start();
        u_mst.wbyte(8'h45, ack);
        chk(24'(ack), 24'h1);
        u_mst.rbyte(1'b1, r0);
        u_mst.rbyte(1'b0, r1);
        u_mst.stop();
        u_mst.pulse();
    endtask : rd
    // Latches, direction and wrap-around within a group
    task automatic s_write();
        wr(8'h86, 8'h5a, 8'h3c);
        wr(8'h8c, 8'h00, 8'h00);
        chk(port_oe_b, 24'hff0000);
        chk(port_d & ~port_oe_b, 24'h00ff3c);
        rd(8'h06);
        chk({r0, r1}, 24'h5a5a);
        rd(8'h80);
        chk({r0, r1}, 24'h3cff);
    endtask : s_write
    // Strap picks address bit 0
    task automatic s_addr();
        u_mst.start();
        u_mst.wbyte(8'h46, ack);
        chk(24'(ack), 24'h0);
        u_mst.stop();
        @(negedge clk_sys) strap = 1'b1;
        u_mst.start();
        u_mst.wbyte(8'h46, ack);
        chk(24'(ack), 24'h1);
        u_mst.stop();
        u_mst.pulse();
        @(negedge clk_sys) strap = 1'b0;
    endtask : s_addr
    // Change interrupt: raise, foreign traffic, read clear, level return
    task automatic s_int();
        @(negedge clk_sys) ext_pins[16] = 1'b0;
        wait_int(1'b0);
        chk(24'(int_line), 24'h0);
        u_mst.start();
        u_mst.wbyte(8'ha0, ack);
        u_mst.stop();
        u_mst.pulse();
        chk(24'(int_line), 24'h0);
        rd(8'h02);
        chk({r0, r1}, 24'h0e0e);
        wait_int(1'b1);
        chk(24'(int_line), 24'h1);
        @(negedge clk_sys) ext_pins[16] = 1'b1;
        wait_int(1'b0);
        chk(24'(int_line), 24'h0);
        @(negedge clk_sys) ext_pins[16] = 1'b0;
        wait_int(1'b1);
        chk(24'(int_line), 24'h1);
    endtask : s_int
    // Supply loss restores the port direction and output latch defaults
    task automatic s_supply();
        @(negedge clk_sys) sup_ok = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk(port_oe_b, 24'hffffff);
        chk(port_d, 24'hffffff);
        @(negedge clk_sys) sup_ok = 1'b1;
    endtask : s_supply
    // Read-direction call to another target; the master plays that
    // target's ack by holding SDA low in the ninth slot
    task automatic other_rd();
        logic       s;
        logic [7:0] adr;
        adr = 8'ha1;
        u_mst.start();
        for (int i = 7; i >= 0; i--) begin
            u_mst.slot(adr[i], s);
        end
        u_mst.slot(1'b0, s);
        u_mst.stop();
        u_mst.pulse();
    endtask : other_rd
    // Pointer left at 00h lets a foreign read ack clear INT; a nonzero
    // pointer written afterwards keeps INT asserted
    task automatic s_flaw();
        rd(8'h00);
        chk({r0, r1}, 24'h3c3c);
        @(negedge clk_sys) ext_pins[17] = 1'b0;
        wait_int(1'b0);
        chk(24'(int_line), 24'h0);
        other_rd();
        wait_int(1'b1);
        chk(24'(int_line), 24'h1);
        wr(8'h8a, 8'h0f, 8'h00);
        rd(8'h0a);
        chk({r0, r1}, 24'h0f0f);
        @(negedge clk_sys) ext_pins[17] = 1'b1;
        wait_int(1'b0);
        other_rd();
        chk(24'(int_line), 24'h0);
    endtask : s_flaw

    // Main sequence
    initial begin
        err_count = 0;
        comparisons = 0;
        rst_b = 1'b0;
        strap = 1'b0;
        sup_ok = 1'b1;
        ext_pins = 24'h0f0000;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk(port_oe_b, 24'hffffff);
        chk({22'h0, int_line, sda}, 24'h3);
        s_write();
        s_addr();
        s_int();
        s_flaw();
        s_supply();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
